// File: hdl/ufn_cfg.svh
// constants for the frame index and low-speed cutoff block
// assumes: included by the frame core module only
`ifndef UFN_CFG_SVH
`define UFN_CFG_SVH

`define UFN_RD_FRAME_INDEX  8'h0F
`define UFN_WR_FRAME_INDEX  8'h8F
`define UFN_RD_LS_LIMIT     8'h11
`define UFN_WR_LS_LIMIT     8'h91
`define UFN_FN_W            16
`define UFN_LST_W           11
`define UFN_FR_W            14
`define UFN_LST_RESET       11'h628
`define UFN_FI_NOMINAL      14'h2EDF
`define UFN_WR_WAIT_CYC     2

`endif

// File: hdl/ufn_pkg.sv
// types for the frame index and low-speed cutoff block
// assumes: compiled before the design modules
package ufn_pkg;
	typedef enum logic [1:0] {
		UFN_IDLE,
		UFN_WRITE,
		UFN_WAIT,
		UFN_DONE
	} ufn_state_t;
endpackage

// File: hdl/ufn_strobe_sync.sv
// two-flop synchroniser for a level input from outside the clock domain
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/1ns
module ufn_strobe_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// level in and out
	input  wire logic async_in,
	output logic      sync_out
);
	logic stage1;

	// first stage is read only by the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// File: hdl/ufn_frame_core.sv
// frame index counter, start-of-frame shared-area write and low-speed cutoff
// assumes: frame timer on the same clock gives reload strobe and bits left;
// memory port of the shared area answers with a one-cycle done pulse
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "ufn_cfg.svh"
module ufn_frame_core
	import ufn_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// command port
	input  wire logic [7:0]             cmd_addr,
	input  wire logic [31:0]            cmd_wdata,
	input  wire logic                   cmd_wr,
	input  wire logic                   cmd_rd,
	output logic      [31:0]            cmd_rdata,
	// frame timer
	input  wire logic                   reload_pulse,
	input  wire logic [`UFN_FR_W-1:0]   bit_times_left,
	input  wire logic                   run_level,
	// shared area write port
	output logic                        shared_wr_req,
	output logic      [15:0]            shared_wr_data,
	input  wire logic                   shared_wr_done,
	// scheduler
	input  wire logic                   sof_sent,
	input  wire logic                   ls_request,
	output logic                        ls_go,
	output logic                        desc_read_ok,
	output logic                        sof_event_flag
);
	logic [`UFN_FN_W-1:0]  frame_count_field;
	logic [`UFN_LST_W-1:0] lowspeed_cutoff;
	logic                  lst_locked;
	logic                  run_sync;
	logic                  run_prev;
	logic                  pend_sof;
	ufn_state_t            state;
	ufn_state_t            next_state;

	// run-state level from the operational control crosses into this domain
	ufn_strobe_sync u_run_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (run_level),
		.sync_out (run_sync)
	);

	// decode of commands
	wire run_entry  = run_sync & ~run_prev;
	// the frame timer counts bit times down and pulses on each reload, so the
	// nominal interval only sets how often this strobe arrives
	wire inc_fn     = reload_pulse | run_entry;
	wire wr_lst     = cmd_wr & (cmd_addr == `UFN_WR_LS_LIMIT);
	wire rd_fn      = cmd_rd & (cmd_addr == `UFN_RD_FRAME_INDEX);
	wire rd_lst     = cmd_rd & (cmd_addr == `UFN_RD_LS_LIMIT);
	wire [`UFN_FN_W-1:0] next_fn = frame_count_field + 16'h0001;     // wraps naturally
	wire [`UFN_FR_W-1:0] lst_ext = {3'h0, lowspeed_cutoff};

	// low-speed admission compares bits left against cutoff
	assign ls_go = ls_request & (bit_times_left >= lst_ext);

	// descriptors may be read only once the index has landed in the area
	assign desc_read_ok = (state == UFN_IDLE) & ~pend_sof;

	// frame index: read-only to software, advance on reload or run entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_count_field <= 16'h0000;
			run_prev          <= 1'b0;
		end else begin
			run_prev <= run_sync;
			if (inc_fn)
				frame_count_field <= next_fn;
		end
	end

	// cutoff takes the first software write, then holds so it never drifts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lowspeed_cutoff <= `UFN_LST_RESET;
			lst_locked      <= 1'b0;
		end else if (wr_lst && !lst_locked) begin
			lowspeed_cutoff <= cmd_wdata[`UFN_LST_W-1:0];
			lst_locked      <= 1'b1;
		end
	end

	// shared-area write sequence after increment and start-of-frame
	always_comb begin
		next_state = state;
		unique case (state)
			UFN_IDLE:  if (pend_sof && sof_sent) next_state = UFN_WRITE;
			UFN_WRITE: next_state = UFN_WAIT;
			UFN_WAIT:  if (shared_wr_done) next_state = UFN_DONE;
			UFN_DONE:  next_state = UFN_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state    <= UFN_IDLE;
			pend_sof <= 1'b0;
		end else begin
			state <= next_state;
			if (inc_fn)
				pend_sof <= 1'b1;
			else if (state == UFN_IDLE && sof_sent)
				pend_sof <= 1'b0;
		end
	end

	// write request and data held from registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shared_wr_req  <= 1'b0;
			shared_wr_data <= 16'h0000;
		end else begin
			if (next_state == UFN_WRITE)
				shared_wr_data <= frame_count_field;
			shared_wr_req <= (next_state == UFN_WRITE) | (next_state == UFN_WAIT);
		end
	end

	// start-of-frame flag: hardware set wins over software clear by code 8F
	wire clr_sf = cmd_wr & (cmd_addr == `UFN_WR_FRAME_INDEX);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sof_event_flag <= 1'b0;
		else if (state == UFN_DONE)
			sof_event_flag <= 1'b1;
		else if (clr_sf)
			sof_event_flag <= 1'b0;
	end

	// read data one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cmd_rdata <= 32'h0000_0000;
		else if (rd_fn)
			cmd_rdata <= {16'h0000, frame_count_field};
		else if (rd_lst)
			cmd_rdata <= {21'h000000, lowspeed_cutoff};
		else
			cmd_rdata <= 32'h0000_0000;
	end

	// checks on the frame index: one step per strobe, never a step without one,
	// so software can safely extend the count by watching the wrap
	fn_step_a: assert property (@(posedge clk) disable iff (rst)
		inc_fn |=> frame_count_field == $past(frame_count_field) + 16'h0001)
		else $error("frame index did not step");

	fn_wrap_a: assert property (@(posedge clk) disable iff (rst)
		inc_fn && frame_count_field == 16'hFFFF |=> frame_count_field == 16'h0000)
		else $error("frame index did not wrap");

	fn_hold_a: assert property (@(posedge clk) disable iff (rst)
		!inc_fn |=> $stable(frame_count_field))
		else $error("frame index moved without cause");

	run_inc_a: assert property (@(posedge clk) disable iff (rst)
		run_entry |=> frame_count_field != $past(frame_count_field))
		else $error("no increment on run entry");

	run_once_a: assert property (@(posedge clk) disable iff (rst)
		run_entry |=> !run_entry)
		else $error("run entry seen twice");

	wr_no_fn_a: assert property (@(posedge clk) disable iff (rst)
		clr_sf && !inc_fn |=> $stable(frame_count_field))
		else $error("index write changed the index");

	pend_set_a: assert property (@(posedge clk) disable iff (rst)
		inc_fn |=> pend_sof)
		else $error("increment left no pending write");

	// checks on the shared-area write sequence; descriptors must wait for it
	write_start_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_IDLE && pend_sof && sof_sent |=> state == UFN_WRITE)
		else $error("write did not start after sof");

	idle_hold_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_IDLE && !(pend_sof && sof_sent) |=> state == UFN_IDLE)
		else $error("write started without cause");

	write_step_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_WRITE |=> state == UFN_WAIT)
		else $error("write did not move to wait");

	wait_hold_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_WAIT && !shared_wr_done |=> state == UFN_WAIT)
		else $error("wait left before done");

	done_idle_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_DONE |=> state == UFN_IDLE)
		else $error("done did not return to idle");

	req_busy_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_WRITE || state == UFN_WAIT |-> shared_wr_req)
		else $error("write request dropped early");

	req_quiet_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_IDLE || state == UFN_DONE |-> !shared_wr_req)
		else $error("write request outside a write");

	wr_data_a: assert property (@(posedge clk) disable iff (rst)
		$rose(shared_wr_req) |-> shared_wr_data == $past(frame_count_field))
		else $error("shared write data wrong");

	pend_clr_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_IDLE && sof_sent && !inc_fn |=> !pend_sof)
		else $error("pending write not taken");

	pend_hold_a: assert property (@(posedge clk) disable iff (rst)
		pend_sof && !(state == UFN_IDLE && sof_sent) |=> pend_sof)
		else $error("pending write lost");

	desc_block_a: assert property (@(posedge clk) disable iff (rst)
		shared_wr_req |-> !desc_read_ok)
		else $error("descriptor read allowed during write");

	desc_pend_a: assert property (@(posedge clk) disable iff (rst)
		pend_sof |-> !desc_read_ok)
		else $error("descriptor read allowed before write");

	desc_free_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_IDLE && !pend_sof |-> desc_read_ok)
		else $error("descriptor read held off when idle");

	// checks on the start-of-frame flag; the hardware set wins over a clear
	sof_after_wr_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_WAIT && shared_wr_done |=> ##1 sof_event_flag)
		else $error("sof flag not set after write");

	flag_set_a: assert property (@(posedge clk) disable iff (rst)
		state == UFN_DONE |=> sof_event_flag)
		else $error("sof flag not set on done");

	flag_clr_a: assert property (@(posedge clk) disable iff (rst)
		clr_sf && state != UFN_DONE |=> !sof_event_flag)
		else $error("sof flag not cleared");

	flag_hold_a: assert property (@(posedge clk) disable iff (rst)
		sof_event_flag && !clr_sf |=> sof_event_flag)
		else $error("sof flag dropped by itself");

	flag_quiet_a: assert property (@(posedge clk) disable iff (rst)
		!sof_event_flag && state != UFN_DONE |=> !sof_event_flag)
		else $error("sof flag set without a write");

	// checks on low-speed admission and the cutoff register
	wire [`UFN_LST_W-1:0] wr_cut = cmd_wdata[`UFN_LST_W-1:0];

	ls_gate_a: assert property (@(posedge clk) disable iff (rst)
		ls_go |-> bit_times_left >= lst_ext)
		else $error("low-speed start below cutoff");

	ls_block_a: assert property (@(posedge clk) disable iff (rst)
		ls_request && bit_times_left < lst_ext |-> !ls_go)
		else $error("low-speed start not refused");

	ls_idle_a: assert property (@(posedge clk) disable iff (rst)
		!ls_request |-> !ls_go)
		else $error("low-speed start without request");

	lst_lock_a: assert property (@(posedge clk) disable iff (rst)
		lst_locked |=> $stable(lowspeed_cutoff))
		else $error("cutoff changed after lock");

	lst_first_a: assert property (@(posedge clk) disable iff (rst)
		wr_lst && !lst_locked |=> lowspeed_cutoff == $past(wr_cut))
		else $error("first cutoff write lost");

	lst_lock_set_a: assert property (@(posedge clk) disable iff (rst)
		wr_lst |=> lst_locked)
		else $error("cutoff not locked after write");

	// checks on read data; they stand one cycle and are zero otherwise
	rd_fn_a: assert property (@(posedge clk) disable iff (rst)
		rd_fn |=> cmd_rdata == {16'h0000, $past(frame_count_field)})
		else $error("frame index read wrong");

	rd_lst_a: assert property (@(posedge clk) disable iff (rst)
		rd_lst |=> cmd_rdata == {21'h000000, $past(lowspeed_cutoff)})
		else $error("cutoff read wrong");

	rd_none_a: assert property (@(posedge clk) disable iff (rst)
		!cmd_rd |=> cmd_rdata == 32'h0000_0000)
		else $error("read data outside a read");

	rd_upper_a: assert property (@(posedge clk) disable iff (rst)
		cmd_rdata[31:16] == 16'h0000)
		else $error("reserved read bits set");
endmodule

// File: verif/tb_ufn_frame_core.sv
// bench for the frame index and low-speed cutoff core
// assumes: design compiled first; bench drives every port, no partner model
`timescale 1ns/1ns
module tb_ufn_frame_core;
	logic        clk = 0, rst = 1, cmd_wr = 0, cmd_rd = 0, run_level = 0;
	logic        reload_pulse = 0, shared_wr_done = 0, sof_sent = 0, ls_request = 0;
	logic [7:0]  cmd_addr = 8'h00;
	logic [31:0] cmd_wdata = 32'h0, cmd_rdata, w;
	logic [13:0] bit_times_left = 14'h0, btl;
	logic [15:0] shared_wr_data, e;
	logic [10:0] cut;
	logic        shared_wr_req, ls_go, desc_read_ok, sof_event_flag, req;
	int          failures = 0, cmp_count = 0, n;

	// 50 MHz clock
	always #10 clk = ~clk;

	ufn_frame_core dut_u (.clk(clk), .rst(rst), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .reload_pulse(reload_pulse),
		.bit_times_left(bit_times_left), .run_level(run_level), .shared_wr_req(shared_wr_req),
		.shared_wr_data(shared_wr_data), .shared_wr_done(shared_wr_done), .sof_sent(sof_sent),
		.ls_request(ls_request), .ls_go(ls_go), .desc_read_ok(desc_read_ok),
		.sof_event_flag(sof_event_flag));

	// start is allowed only when enough bit times remain
	function automatic logic ls_exp(input logic r, input logic [13:0] b, input logic [10:0] c);
		return r & (b >= {3'h0, c});
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clk);
		cmd_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge clk);
		cmd_rd <= 1'b0;
		#1 chk(cmd_rdata, exp);
	endtask

	// bounded wait; a level that never comes counts as a mismatch
	task automatic await(ref logic s, input logic v);
		int k;
		k = 0;
		while (s !== v && k < 40) begin
			@(posedge clk);
			#1 k++;
		end
		chk(32'(s), 32'(v));
	endtask

	// one frame boundary: n reload strobes, or run entry when n is zero
	task automatic frame(input int n, input logic [15:0] exp);
		@(posedge clk);
		if (n == 0) run_level <= 1'b1;
		else reload_pulse <= 1'b1;
		repeat (n) @(posedge clk);
		reload_pulse <= 1'b0;
		#1 await(desc_read_ok, 1'b0);
		@(posedge clk);
		sof_sent <= 1'b1;
		@(posedge clk);
		sof_sent <= 1'b0;
		#1 await(shared_wr_req, 1'b1);
		chk({16'h0, shared_wr_data}, {16'h0, exp});
		chk(32'(sof_event_flag | desc_read_ok), 32'h0);
		@(posedge clk);
		shared_wr_done <= 1'b1;
		@(posedge clk);
		shared_wr_done <= 1'b0;
		#1 await(sof_event_flag, 1'b1);
		chk(32'(desc_read_ok), 32'h1);
		rd(8'h0F, {16'h0, exp});
		wr(8'h8F, $urandom);
		rd(8'h0F, {16'h0, exp});
		chk(32'(sof_event_flag), 32'h0);
	endtask

	task automatic close_out;
		if (failures == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// watchdog at 80k cycles, above the roughly 66k cycles of the run
	initial begin
		#1600000;
		failures++;
		close_out;
	end

	initial begin
		void'($urandom(32'h44A93BC5));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(8'h0F, 32'h0);
		rd(8'h11, 32'h628);
		rd(8'h12, 32'h0);
		frame(0, 16'h0001);
		frame(65534, 16'hFFFF);
		frame(1, 16'h0000);
		e = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			n = $urandom_range(3, 1);
			e = e + 16'(n);
			frame(n, e);
		end
		w = $urandom;
		cut = w[10:0];
		wr(8'h91, w);
		rd(8'h11, {21'h0, cut});
		wr(8'h91, ~w);
		rd(8'h11, {21'h0, cut});
		// boundary values first, then random ones
		for (int i = 0; i < 40; i++) begin
			req = (i < 2) ? 1'b1 : 1'($urandom);
			btl = (i < 2) ? 14'({3'h0, cut} - 14'(i)) : 14'($urandom);
			@(posedge clk);
			ls_request <= req;
			bit_times_left <= btl;
			#1 chk(32'(ls_go), 32'(ls_exp(req, btl, cut)));
		end
		close_out;
	end
endmodule
